// ---- src/sasfs_pkg.sv ----
// sasfs_pkg: constants for the smbus target front end and fan start logic
`default_nettype none

package sasfs_pkg;
  localparam int unsigned CLK_MHZ     = 250;
  localparam int unsigned TIMEOUT_MS  = 25;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * CLK_MHZ * 1000;

  localparam logic [4:0] ADDR_PREFIX  = 5'h0B;
  localparam logic [6:0] ADDR_EN_SEL0 = 7'h2C;
  localparam logic [6:0] ADDR_EN_SEL1 = 7'h2D;
  localparam logic [6:0] ADDR_DEFAULT = 7'h2E;

  localparam logic [7:0] REG_TEMP1  = 8'h25;
  localparam logic [7:0] REG_TEMP3  = 8'h27;
  localparam logic [7:0] REG_DUTY1  = 8'h30;
  localparam logic [7:0] REG_DUTY3  = 8'h32;
  localparam logic [7:0] REG_CTRL   = 8'h40;
  localparam logic [7:0] REG_PAR_LO = 8'h5C;
  localparam logic [7:0] REG_PAR_HI = 8'h6E;

  localparam int NFAN     = 3;
  localparam int NPAR     = 19;
  localparam int CFG_OFS  = 0;
  localparam int MIN_OFS  = 8;
  localparam int TMIN_OFS = 11;
  localparam int ABS_OFS  = 14;
  localparam int ZONE_LSB = 5;

  localparam int CTRL_START = 0;
  localparam int CTRL_LOCK  = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_MASK  = 8'h0F;

  localparam logic [7:0] PAR_RESET = 8'h00;
  localparam logic [7:0] MIN_DEF   = 8'h80;
  localparam logic [7:0] TMIN_DEF  = 8'h5A;
  localparam logic [7:0] ABS_DEF   = 8'h64;
  localparam logic [7:0] FULL_DUTY = 8'hFF;
  localparam logic [7:0] PWM_DIV   = 8'h20;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_WRX  = 7'h08,
    ST_WACK = 7'h10,
    ST_TX   = 7'h20,
    ST_TACK = 7'h40
  } sasfs_state_e;

  function automatic logic [7:0] sasfs_par_def(input int idx);
    if (idx < NFAN)
      sasfs_par_def = {3'(idx + 1), 5'h00};
    else if (idx < MIN_OFS)
      sasfs_par_def = PAR_RESET;
    else if (idx < TMIN_OFS)
      sasfs_par_def = MIN_DEF;
    else if (idx < ABS_OFS)
      sasfs_par_def = TMIN_DEF;
    else if (idx < ABS_OFS + NFAN)
      sasfs_par_def = ABS_DEF;
    else
      sasfs_par_def = PAR_RESET;
  endfunction
endpackage

`default_nettype wire

// ---- src/sasfs_sync.sv ----
// sasfs_sync: two-stage synchroniser for pins from outside the mclk domain
`timescale 1ns/10ps
`default_nettype none

module sasfs_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // pins in, synchronised levels out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;

  // idle level of open-drain lines is high
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta <= '1;
      dout <= '1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // sasfs_sync

`default_nettype wire

// ---- src/sasfs_top.sv ----
// sasfs_top: smbus target, address strapping and fan start control
`timescale 1ns/10ps
`default_nettype none

module sasfs_top
  import sasfs_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // smbus pins
  input  wire logic       smb_scl,
  input  wire logic       smb_sda_i,
  output logic            smb_sda_o,
  output logic            smb_sda_oe,
  // shared strap pins
  input  wire logic       third_fan_drive_output_i,
  output logic            third_fan_drive_output_o,
  output logic            third_fan_drive_output_oe,
  input  wire logic       fourth_speed_sense_input,
  output logic            fourth_speed_sense_level,
  output logic            address_strap_active,
  // conversion results
  input  wire logic       conv_done,
  input  wire logic [7:0] zone1_temp,
  input  wire logic [7:0] zone2_temp,
  input  wire logic [7:0] zone3_temp,
  // fan outputs
  output logic            fan1_pwm,
  output logic            fan2_pwm,
  output logic            full_duty_active
);
  logic scl_s, sda_s, pin3_s, fourth_speed_sense_input_s;
  logic scl_q, sda_q;

  sasfs_sync #(.W(4)) u_sync (
    .mclk  (mclk),
    .reset (reset),
    .din   ({smb_scl, smb_sda_i, third_fan_drive_output_i,
             fourth_speed_sense_input}),
    .dout  ({scl_s, sda_s, pin3_s, fourth_speed_sense_input_s})
  );

  always_ff @(posedge mclk) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c  = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c   = scl_s & scl_q & ~sda_q & sda_s;

  // bus-low timeout
  logic [31:0] to_cnt, next_to_cnt;
  logic        bus_low, to_evt;
  assign bus_low = ~scl_s | ~sda_s;
  assign to_evt  = bus_low && (to_cnt == TIMEOUT_CYCLES - 1);

  always_comb begin
    if (!bus_low)
      next_to_cnt = '0;
    else if (to_cnt != TIMEOUT_CYCLES)
      next_to_cnt = to_cnt + 32'h1;
    else
      next_to_cnt = to_cnt;
  end

  always_ff @(posedge mclk) begin
    if (reset)
      to_cnt <= '0;
    else
      to_cnt <= next_to_cnt;
  end

  // smbus target state
  sasfs_state_e st, next_st;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] shreg, next_shreg, ptr, next_ptr, rd_data, byte_in;
  logic       ptr_phase, next_ptr_phase, rw, next_rw, drv, next_drv;
  logic       hit, next_hit, addr_locked, next_addr_locked;
  logic       strap_mode, next_strap_mode, wr_en;
  logic [6:0] addr_lat, next_addr_lat, strap_addr, tgt_addr;

  assign byte_in    = {shreg[6:0], sda_s};
  assign strap_addr = pin3_s ? ADDR_DEFAULT :
                      (fourth_speed_sense_input_s ? ADDR_EN_SEL1 : ADDR_EN_SEL0);
  assign tgt_addr   = addr_locked ? addr_lat : strap_addr;

  always_comb begin
    next_st = st;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_ptr = ptr;
    next_ptr_phase = ptr_phase;
    next_rw = rw;
    next_drv = drv;
    next_hit = hit;
    next_addr_locked = addr_locked;
    next_addr_lat = addr_lat;
    next_strap_mode = strap_mode;
    wr_en = 1'b0;
    if (to_evt) begin
      next_st = ST_IDLE;
      next_drv = 1'b0;
      next_hit = 1'b0;
    end else if (start_c) begin
      next_st = ST_ADDR;
      next_bitcnt = 4'h0;
      next_drv = 1'b0;
      next_ptr_phase = 1'b1;
    end else if (stop_c) begin
      next_st = ST_IDLE;
      next_drv = 1'b0;
      next_hit = 1'b0;
      if (hit)
        next_strap_mode = 1'b0;
    end else begin
      case (st)
        ST_ADDR: if (scl_rise) begin
          next_shreg = byte_in;
          next_bitcnt = bitcnt + 4'h1;
          if (bitcnt == 4'h7) begin
            // glitches with a foreign prefix never fix the address
            if (byte_in[7:3] == ADDR_PREFIX && !addr_locked) begin
              next_addr_locked = 1'b1;
              next_addr_lat = strap_addr;
            end
            if (byte_in[7:1] == tgt_addr) begin
              next_st = ST_AACK;
              next_rw = byte_in[0];
              next_hit = 1'b1;
            end else begin
              next_st = ST_IDLE;
            end
          end
        end
        ST_AACK: if (scl_fall) begin
          if (!drv) begin
            next_drv = 1'b1;
          end else if (rw) begin
            next_st = ST_TX;
            next_shreg = rd_data;
            next_drv = ~rd_data[7];
            next_ptr = ptr + 8'h01;
            next_bitcnt = 4'h0;
          end else begin
            next_st = ST_WRX;
            next_drv = 1'b0;
            next_bitcnt = 4'h0;
          end
        end
        ST_WRX: if (scl_rise) begin
          next_shreg = byte_in;
          next_bitcnt = bitcnt + 4'h1;
          if (bitcnt == 4'h7) begin
            next_st = ST_WACK;
            if (ptr_phase) begin
              next_ptr = byte_in;
              next_ptr_phase = 1'b0;
            end else begin
              wr_en = 1'b1;
              next_ptr = ptr + 8'h01;
            end
          end
        end
        ST_WACK: if (scl_fall) begin
          next_drv = ~drv;
          if (drv) begin
            next_st = ST_WRX;
            next_bitcnt = 4'h0;
          end
        end
        ST_TX: if (scl_fall) begin
          if (bitcnt == 4'h7) begin
            next_drv = 1'b0;
            next_st = ST_TACK;
          end else begin
            next_shreg = {shreg[6:0], 1'b0};
            next_drv = ~shreg[6];
            next_bitcnt = bitcnt + 4'h1;
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            if (sda_s)
              next_st = ST_IDLE;
            else
              next_bitcnt = 4'h8;
          end else if (scl_fall && bitcnt == 4'h8) begin
            next_st = ST_TX;
            next_shreg = rd_data;
            next_drv = ~rd_data[7];
            next_ptr = ptr + 8'h01;
            next_bitcnt = 4'h0;
          end
        end
        default: next_st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      ptr_phase <= 1'b0;
      rw <= 1'b0;
      drv <= 1'b0;
      hit <= 1'b0;
      addr_locked <= 1'b0;
      addr_lat <= ADDR_DEFAULT;
      strap_mode <= 1'b1;
    end else begin
      st <= next_st;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      ptr <= next_ptr;
      ptr_phase <= next_ptr_phase;
      rw <= next_rw;
      drv <= next_drv;
      hit <= next_hit;
      addr_locked <= next_addr_locked;
      addr_lat <= next_addr_lat;
      strap_mode <= next_strap_mode;
    end
  end

  assign smb_sda_o  = 1'b0;
  assign smb_sda_oe = drv;

  // register file
  logic [7:0] ctrl, next_ctrl;
  logic [7:0] prog [NPAR];
  logic [7:0] next_prog [NPAR];
  logic [7:0] zt [NFAN];
  logic [7:0] next_zt [NFAN];
  logic [7:0] duty [NFAN];
  logic [7:0] next_duty [NFAN];
  logic       in_par;
  logic [4:0] pidx;

  assign in_par = (ptr >= REG_PAR_LO) && (ptr <= REG_PAR_HI);
  assign pidx   = 5'(ptr - REG_PAR_LO);

  always_comb begin
    rd_data = 8'h00;
    if (ptr >= REG_TEMP1 && ptr <= REG_TEMP3)
      rd_data = zt[2'(ptr - REG_TEMP1)];
    else if (ptr >= REG_DUTY1 && ptr <= REG_DUTY3)
      rd_data = duty[2'(ptr - REG_DUTY1)];
    else if (ptr == REG_CTRL)
      rd_data = ctrl;
    else if (in_par)
      rd_data = prog[pidx];
  end

  always_comb begin
    next_ctrl = ctrl;
    next_prog = prog;
    next_zt = zt;
    if (conv_done) begin
      next_zt[0] = zone1_temp;
      next_zt[1] = zone2_temp;
      next_zt[2] = zone3_temp;
    end
    if (wr_en) begin
      if (ptr == REG_CTRL) begin
        next_ctrl = byte_in & CTRL_MASK;
        next_ctrl[CTRL_LOCK] = byte_in[CTRL_LOCK] | ctrl[CTRL_LOCK];
      end else if (in_par && !ctrl[CTRL_LOCK]) begin
        next_prog[pidx] = byte_in;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
      for (int k = 0; k < NPAR; k++)
        prog[k] <= sasfs_par_def(k);
      for (int k = 0; k < NFAN; k++)
        zt[k] <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
      prog <= next_prog;
      zt <= next_zt;
    end
  end

  // pwm timebase and auto fan control
  logic [7:0] div, next_div, pwm_cnt, next_pwm_cnt;
  logic [NFAN-1:0] hot, pwm, next_pwm;
  logic [7:0] act_cfg0;

  always_comb begin
    next_div = div + 8'h01;
    next_pwm_cnt = pwm_cnt;
    if (div == PWM_DIV - 8'h01) begin
      next_div = 8'h00;
      next_pwm_cnt = pwm_cnt + 8'h01;
    end
  end

  for (genvar i = 0; i < NFAN; i++) begin : g_fan
    logic [7:0]  cfg, mind, tmin, absl, temp, dlt, auto_d;
    logic [11:0] ramp;
    always_comb begin
      // defaults stay in force until the host commits with start
      cfg  = ctrl[CTRL_START] ? prog[CFG_OFS + i]
                              : sasfs_par_def(CFG_OFS + i);
      mind = ctrl[CTRL_START] ? prog[MIN_OFS + i]
                              : sasfs_par_def(MIN_OFS + i);
      tmin = ctrl[CTRL_START] ? prog[TMIN_OFS + i]
                              : sasfs_par_def(TMIN_OFS + i);
      absl = ctrl[CTRL_START] ? prog[ABS_OFS + i]
                              : sasfs_par_def(ABS_OFS + i);
      case (cfg[7:ZONE_LSB])
        3'h2:    temp = zt[1];
        3'h3:    temp = zt[2];
        default: temp = zt[0];
      endcase
      dlt  = temp - tmin;
      ramp = {4'h0, mind} + {1'b0, dlt, 3'h0};
      if (temp < tmin)
        auto_d = mind;
      else if (|ramp[11:8])
        auto_d = FULL_DUTY;
      else
        auto_d = ramp[7:0];
    end
    assign hot[i]       = zt[i] > absl;
    assign next_duty[i] = (|hot) ? FULL_DUTY : auto_d;
    assign next_pwm[i]  = (duty[i] == FULL_DUTY) || (pwm_cnt < duty[i]);
  end

  assign act_cfg0 = g_fan[0].cfg;

  always_ff @(posedge mclk) begin
    if (reset) begin
      div <= 8'h00;
      pwm_cnt <= 8'h00;
      pwm <= '0;
      for (int k = 0; k < NFAN; k++)
        duty[k] <= 8'h00;
    end else begin
      div <= next_div;
      pwm_cnt <= next_pwm_cnt;
      pwm <= next_pwm;
      duty <= next_duty;
    end
  end

  // strap pin left undriven in strap mode so the pull-up or pull-down shows
  assign third_fan_drive_output_o  = 1'b0;
  assign third_fan_drive_output_oe = ~strap_mode & ~pwm[2];
  assign fourth_speed_sense_level  = ~strap_mode & fourth_speed_sense_input_s;
  assign address_strap_active      = strap_mode;
  assign fan1_pwm         = pwm[0];
  assign fan2_pwm         = pwm[1];
  assign full_duty_active = (duty[0] == FULL_DUTY) && (duty[1] == FULL_DUTY)
                            && (duty[2] == FULL_DUTY);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  AST_TIMEOUT_RELEASE: assert property (
    to_evt |=> (st == ST_IDLE) && !smb_sda_oe ##1 !smb_sda_oe)
    else $error("sda still driven after bus timeout");
  AST_TIMEOUT_BOUND: assert property (
    to_evt |-> bus_low && $past(bus_low) && to_cnt == TIMEOUT_CYCLES - 1)
    else $error("bus timeout fired early");
  AST_READ_LATEST: assert property (
    conv_done |=> zt[0] == $past(zone1_temp) && zt[2] == $past(zone3_temp))
    else $error("conversion result not captured");
  AST_STRAP_INPUT: assert property (
    strap_mode |-> !third_fan_drive_output_oe && !fourth_speed_sense_level)
    else $error("strap pin driven during strapping");
  AST_LATCH_ONCE: assert property (
    addr_locked |=> addr_locked && $stable(addr_lat))
    else $error("latched address changed");
  AST_ADDR_MAP: assert property (
    $rose(addr_locked) |-> addr_lat == $past(strap_addr))
    else $error("latched address differs from strap");
  AST_ADDR_DEFAULT: assert property (
    ($rose(addr_locked) && $past(pin3_s)) |-> addr_lat == ADDR_DEFAULT)
    else $error("enable high did not give default address");
  AST_STRAP_END: assert property (
    (stop_c && hit && !to_evt) |=> !strap_mode [*2])
    else $error("shared pins stayed in strap mode");
  AST_DEFAULTS: assert property (
    !ctrl[CTRL_START] |-> act_cfg0 == sasfs_par_def(CFG_OFS))
    else $error("fan control left defaults before start");
  AST_ADOPT: assert property (
    ctrl[CTRL_START] |-> act_cfg0 == prog[CFG_OFS])
    else $error("programmed values not adopted");
  AST_LOCK_HOLD: assert property (
    ctrl[CTRL_LOCK] |=> ctrl[CTRL_LOCK] && $stable(prog[TMIN_OFS]))
    else $error("locked parameter changed");
  AST_FULL_DUTY: assert property (
    (|hot) |=> full_duty_active ##1 (pwm == '1 || !$past(|hot)))
    else $error("hot zone did not force full duty");

  COV_ADDRESSED: cover property ($rose(hit) ##[1:1000] stop_c);
  COV_START: cover property ($rose(ctrl[CTRL_START]));
  COV_LOCK: cover property ($rose(ctrl[CTRL_LOCK]));
  COV_TIMEOUT: cover property (to_evt);
endmodule // sasfs_top

`default_nettype wire

// ---- test/sasfs_host.sv ----
// sasfs_host: smbus host model driving the target's clock and data pins
`timescale 1ns/10ps
`default_nettype none

module sasfs_host (
  // bus lines
  input  wire logic       sda,
  input  wire logic       slow,
  output logic            scl,
  output logic            sda_low,
  // results seen by the host
  output logic            res_stb,
  output logic [7:0]      res_val
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    res_stb = 1'b0;
    res_val = 8'h00;
  end

  // data moves 12 ns after scl falls so the target's
  // synchroniser never sees it as a start or stop
  task automatic bit_io(input logic b, output logic r);
    #12 sda_low = !b;
    #(slow ? 60 : 12) scl = 1'b1;
    r = sda;
    #24 scl = 1'b0;
  endtask

  task automatic start();
    if (!scl) begin
      #12 sda_low = 1'b0;
      #12 scl = 1'b1;
      #24;
    end
    sda_low = 1'b1;
    #24 scl = 1'b0;
  endtask

  task automatic stop();
    #12 sda_low = 1'b1;
    #12 scl = 1'b1;
    #24 sda_low = 1'b0;
    #48;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // single byte reads only, so the host always ends with a nack
  task automatic rbyte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
  endtask

  task automatic put(input logic [7:0] v);
    res_val = v;
    res_stb = 1'b1;
    #1 res_stb = 1'b0;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] p, d);
    logic k;
    start();
    wbyte({a, 1'b0}, k);
    put({7'h00, k});
    if (k) begin
      wbyte(p, k);
      wbyte(d, k);
    end
    stop();
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] p);
    logic       k;
    logic [7:0] d;
    start();
    wbyte({a, 1'b0}, k);
    put({7'h00, k});
    if (k) begin
      wbyte(p, k);
      start();
      wbyte({a, 1'b1}, k);
      rbyte(d);
      put(d);
    end
    stop();
  endtask

  // address byte, then scl parked low with the ack slot released
  task automatic stall(input logic [6:0] a);
    logic r;
    start();
    for (int i = 7; i >= 1; i--)
      bit_io(a[i-1], r);
    bit_io(1'b0, r);
    #12 sda_low = 1'b0;
  endtask

  task automatic release_bus();
    #12 sda_low = 1'b0;
    #12 scl = 1'b1;
    #48;
  endtask
endmodule // sasfs_host

`default_nettype wire

// ---- test/tb.sv ----
// tb: self-checking bench for the smbus target and fan start logic
`timescale 1ns/10ps
`default_nettype none

module tb
  import sasfs_pkg::*;
;
  // long enough that a byte of zeros plus ack at the slow rate never trips it
  localparam int unsigned TO = 400;
  logic       mclk = 1'b0;
  logic       reset = 1'b1;
  logic       slow = 1'b0;
  logic       scl, sda_low, sda, sda_oe, pin3, pin3_oe, strap, full;
  logic       sda_o, pin3_o, f1, f2;
  logic       pin3_pull = 1'b1;
  logic       tach = 1'b0;
  logic       tach_lvl, res_stb;
  logic       conv = 1'b0;
  logic [7:0] z1 = 8'h00, z2 = 8'h00, z3 = 8'h00, res_val, t1, t2;
  logic [6:0] a;
  logic [6:0] adr [3] = '{7'h2C, 7'h2D, 7'h2E};
  logic [31:0] seed = 32'hEFF04B8A;
  logic [7:0] q [$];
  int         failures = 0;
  int         n_checks = 0;

  // open-drain lines; sda pulled up, pin3 pulled to pin3_pull
  assign sda = !sda_low & (sda_oe ? sda_o : 1'b1);
  assign pin3 = pin3_oe ? pin3_o : pin3_pull;

  always #2 mclk = ~mclk;

  sasfs_top #(.TIMEOUT_CYCLES(TO)) dut (
    .mclk(mclk), .reset(reset), .smb_scl(scl), .smb_sda_i(sda),
    .smb_sda_o(sda_o), .smb_sda_oe(sda_oe),
    .third_fan_drive_output_i(pin3), .third_fan_drive_output_o(pin3_o),
    .third_fan_drive_output_oe(pin3_oe),
    .fourth_speed_sense_input(tach), .fourth_speed_sense_level(tach_lvl),
    .address_strap_active(strap), .conv_done(conv),
    .zone1_temp(z1), .zone2_temp(z2), .zone3_temp(z3),
    .fan1_pwm(f1), .fan2_pwm(f2), .full_duty_active(full));

  sasfs_host h (.sda(sda), .slow(slow), .scl(scl), .sda_low(sda_low),
    .res_stb(res_stb), .res_val(res_val));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [7:0] e, g, input string m);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t %s exp %h got %h", $time, m, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [6:0] ad, input logic [7:0] p, d,
                    input logic k);
    q.push_back({7'h00, k});
    h.wr(ad, p, d);
  endtask

  task automatic rd(input logic [6:0] ad, input logic [7:0] p, e);
    q.push_back(8'h01);
    q.push_back(e);
    h.rd(ad, p);
  endtask

  task automatic conv_set(input logic [7:0] a1, a2, a3);
    // host tasks end off the clock grid; realign before same-clock inputs
    cyc(1);
    z1 = a1;
    z2 = a2;
    z3 = a3;
    conv = 1'b1;
    cyc(1);
    conv = 1'b0;
    cyc(6);
  endtask

  task automatic do_reset();
    reset = 1'b1;
    cyc(16);
    reset = 1'b0;
    cyc(4);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge res_stb) begin
    if (q.size() == 0) begin
      failures++;
      $display("[ERR] %0t unexpected bus result", $time);
    end else
      chk(q.pop_front(), res_val, "bus result");
  end

  initial begin
    for (int c = 0; c < 3; c++) begin
      do_reset();
      pin3_pull = (c == 2);
      tach = (c != 1);
      slow = (c == 1);
      cyc(4);
      chk(8'h01, {7'h00, strap}, "strap mode");
      chk(8'h00, {7'h00, pin3_oe}, "enable pin released");
      // prefix mismatch must not freeze the select level seen here
      wr(7'h28, REG_CTRL, 8'h00, 1'b0);
      tach = (c == 1);
      cyc(4);
      rd(adr[c], REG_CTRL, 8'h00);
      chk(8'h00, {7'h00, strap}, "strap ended");
      wr(adr[(c + 1) % 3], REG_CTRL, 8'h00, 1'b0);
      tach = 1'b1;
      cyc(6);
      chk(8'h01, {7'h00, tach_lvl}, "tach level");
      $display("test strap case %0d done", c);
    end
    slow = 1'b0;
    a = 7'h2E;
    seed = lfsr(seed);
    t1 = {2'b00, seed[5:0]};
    t2 = {2'b00, seed[13:8]};
    conv_set(t1, t2, 8'h5C);
    rd(a, REG_TEMP1, t1);
    rd(a, REG_DUTY1, 8'h80);
    rd(a, REG_DUTY3, 8'h90);
    wr(a, 8'h64, 8'h40, 1'b1);
    wr(a, 8'h5D, 8'h60, 1'b1);
    rd(a, REG_DUTY1, 8'h80);
    rd(a, 8'h31, 8'h80);
    wr(a, REG_CTRL, 8'h01, 1'b1);
    rd(a, REG_DUTY1, 8'h40);
    rd(a, 8'h31, 8'h90);
    wr(a, REG_CTRL, 8'h03, 1'b1);
    wr(a, 8'h64, 8'h20, 1'b1);
    rd(a, 8'h64, 8'h40);
    conv_set(8'h65, t2, 8'h5C);
    chk(8'h01, {7'h00, full}, "full duty flag");
    chk(8'h03, {6'h00, f2, f1}, "pwm outputs full");
    for (int i = 0; i < 3; i++)
      rd(a, 8'h30 + 8'(i), 8'hFF);
    rd(a, REG_TEMP1, 8'h65);
    $display("test fan start done");
    h.stall(a);
    // the bus has already been low for about 25 cycles here
    cyc(TO - 40);
    chk(8'h01, {7'h00, sda_oe}, "ack held");
    cyc(60);
    chk(8'h00, {7'h00, sda_oe}, "bus released");
    h.release_bus();
    rd(a, REG_CTRL, 8'h03);
    $display("test bus timeout done");
    cyc(10);
    if (q.size() != 0) begin
      failures++;
      $display("[ERR] %0t bus results missing", $time);
    end
    complete_run();
  end

  initial begin
    #300000;
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
endmodule // tb

`default_nettype wire
